//--- hdl/swic_defs.svh
// Purpose: offsets, fields, reset values of the sleep/wake control
// Assumes: 32-bit apb, one aligned word per register
// Notes: definitions only
`ifndef SWIC_DEFS_SVH
`define SWIC_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SWIC_OFS_CTRL 8'h2C
`define SWIC_OFS_ROUTE 8'h30
`define SWIC_OFS_STAT 8'h34
`define SWIC_OFS_MASK 8'h38
`define SWIC_OFS_MODE 8'h3C
// ----------------------------------------
// reset values
// ----------------------------------------
`define SWIC_RST_CTRL 8'h00
`define SWIC_RST_ROUTE 8'h00
`define SWIC_RST_MASK 3'h0
// ----------------------------------------
// status bit positions
// ----------------------------------------
`define SWIC_ST_GERR 0
`define SWIC_ST_FLUSH 1
`define SWIC_ST_WAKE 2
// ----------------------------------------
// mode status bit positions
// ----------------------------------------
`define SWIC_MD_SLEEP 0
`define SWIC_MD_GERR 1
`define SWIC_MD_BLOCK 2
`endif

//--- hdl/swic_pkg.sv
// Purpose: types of the sleep/wake interrupt control block
// Assumes: nothing beyond the defs header
// Notes: field order follows the 8-bit control register, msb first
package swic_pkg;
  // ----------------------------------------
  // control register layout
  // ----------------------------------------
  typedef struct packed {
    logic fifo_gate; // bit 7: block fifo input on mode change
    logic wake_trans; // bit 6: transient runs in sleep
    logic wake_orient; // bit 5: orientation runs in sleep
    logic wake_pulse; // bit 4: pulse/tap runs in sleep
    logic wake_ffmt; // bit 3: freefall/motion runs in sleep
    logic wake_vecm; // bit 2: vector magnitude runs in sleep
    logic irq_pin_pol; // bit 1: 1 active high pins
    logic irq_pin_drive_type; // bit 0: 1 open drain
  } swic_ctrl_t;
  // ----------------------------------------
  // acceleration event functions
  // ----------------------------------------
  typedef struct packed {
    logic trans;
    logic orient;
    logic pulse;
    logic ffmt;
    logic vecm;
  } swic_func_t;
  // one interrupt pin as level and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } swic_pin_t;
endpackage

//--- hdl/swic_top.sv
// Purpose: sleep/wake fifo gating, wake enables, interrupt pin control
// Assumes: all sensor side inputs come from logic on ref_clk
// Notes: apb slave, zero wait states, read data from a flop
`timescale 1ns/1ps
`include "swic_defs.svh"
module swic_top #(
  parameter int RATE_W = 3
) (
  input wire logic ref_clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system state from the mode controller
  input wire logic sys_sleep,
  input wire logic auto_sleep_en,
  input wire logic [RATE_W-1:0] output_sample_rate,
  // fifo data path
  input wire logic sample_valid,
  input wire logic fifo_empty,
  output logic fifo_flush,
  output logic fifo_in_block,
  // event functions
  input wire swic_pkg::swic_func_t func_event,
  output swic_pkg::swic_func_t func_enable,
  output logic func_cnt_reset,
  output logic wake_req,
  // interrupt pins
  output swic_pkg::swic_pin_t event_pin_a,
  output swic_pkg::swic_pin_t event_pin_b,
  output logic irq
);
  import swic_pkg::*;

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (RATE_W < 1 || RATE_W > 8) begin : g_chk
    $error("RATE_W must lie in 1..8");
  end

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  swic_ctrl_t ctrl_reg; // control register
  logic [7:0] route_reg; // low five bits: 1 to pin a
  logic [2:0] stat_reg; // sticky events
  logic [2:0] stat_next;
  logic [2:0] mask_reg; // interrupt mask
  logic gerr_reg; // gate error flag
  logic block_reg; // fifo input held off
  logic sleep_reg; // last seen mode
  logic [RATE_W-1:0] rate_reg; // last seen rate
  logic [31:0] rdata_reg; // read data
  logic flush_reg; // flush pulse
  logic cnt_rst_reg; // counter reset pulse
  logic wake_reg; // wake request pulse
  swic_pin_t pin_a_reg;
  swic_pin_t pin_b_reg;
  logic mode_chg; // sleep/wake transition
  logic rate_chg; // rate change
  logic wr_acc; // write access phase
  logic rd_acc; // read access phase
  logic setup; // setup phase
  logic addr_ok; // mapped address
  logic [4:0] evt_v; // events as a vector
  logic [4:0] wake_v; // wake enables as a vector
  logic [4:0] live_v; // events of running functions
  logic [4:0] func_en_v; // functions allowed to run
  logic src_a; // ored pin a sources
  logic src_b; // ored pin b sources
  logic set_gerr;
  logic set_flush;
  logic set_wake;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  // zero wait states: answer in the access phase
  assign pready = psel & penable;
  // unmapped address answers with an error
  assign pslverr = psel & penable & ~addr_ok;

  // address decode
  always_comb begin
    case (paddr)
      `SWIC_OFS_CTRL,
      `SWIC_OFS_ROUTE,
      `SWIC_OFS_STAT,
      `SWIC_OFS_MASK,
      `SWIC_OFS_MODE: begin
        addr_ok = 1'b1;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  // control register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `SWIC_RST_CTRL;
    end else if (wr_acc && paddr == `SWIC_OFS_CTRL) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  // routing register, upper bits read as zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      route_reg <= `SWIC_RST_ROUTE;
    end else if (wr_acc && paddr == `SWIC_OFS_ROUTE) begin
      route_reg <= {3'h0, pwdata[4:0]};
    end
  end

  // interrupt mask
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= `SWIC_RST_MASK;
    end else if (wr_acc && paddr == `SWIC_OFS_MASK) begin
      mask_reg <= pwdata[2:0];
    end
  end

  // ----------------------------------------
  // read data, captured in the setup phase
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0;
    end else if (setup) begin
      case (paddr)
        `SWIC_OFS_CTRL: begin
          rdata_reg <= {24'h0, ctrl_reg};
        end
        `SWIC_OFS_ROUTE: begin
          rdata_reg <= {24'h0, route_reg};
        end
        `SWIC_OFS_STAT: begin
          rdata_reg <= {29'h0, stat_reg};
        end
        `SWIC_OFS_MASK: begin
          rdata_reg <= {29'h0, mask_reg};
        end
        `SWIC_OFS_MODE: begin
          rdata_reg <= {29'h0, block_reg, gerr_reg, sleep_reg};
        end
        default: begin
          rdata_reg <= 32'h0;
        end
      endcase
    end
  end
  assign prdata = rdata_reg;

  // ----------------------------------------
  // mode and rate tracking
  // ----------------------------------------
  // previous mode and rate, for change detection
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sleep_reg <= 1'b0;
      rate_reg <= '0;
    end else begin
      sleep_reg <= sys_sleep;
      rate_reg <= output_sample_rate;
    end
  end
  // the first cycle after reset sees wake and rate zero as old
  assign mode_chg = sys_sleep ^ sleep_reg;
  assign rate_chg = output_sample_rate != rate_reg;

  // ----------------------------------------
  // fifo gate
  // ----------------------------------------
  // input block, released once the host has emptied the fifo
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      block_reg <= 1'b0;
    end else if (mode_chg && ctrl_reg.fifo_gate) begin
      block_reg <= 1'b1;
    end else if (fifo_empty) begin
      block_reg <= 1'b0;
    end
  end
  assign fifo_in_block = block_reg;

  // gate error flag; only emptying clears it
  assign set_gerr = block_reg & sample_valid & ~fifo_empty;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gerr_reg <= 1'b0;
    end else if (set_gerr) begin
      gerr_reg <= 1'b1;
    end else if (fifo_empty) begin
      gerr_reg <= 1'b0;
    end
  end

  // flush and counter reset pulses
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flush_reg <= 1'b0;
      cnt_rst_reg <= 1'b0;
    end else begin
      // bypassed gate flushes; rate change flushes
      flush_reg <= (mode_chg & ~ctrl_reg.fifo_gate) | rate_chg;
      // reset counters, status is kept elsewhere
      cnt_rst_reg <= mode_chg & auto_sleep_en;
    end
  end
  assign fifo_flush = flush_reg;
  assign func_cnt_reset = cnt_rst_reg;

  // ----------------------------------------
  // sleep operation of event functions
  // ----------------------------------------
  assign evt_v = func_event;
  assign wake_v = {ctrl_reg.wake_trans, ctrl_reg.wake_orient,
                   ctrl_reg.wake_pulse, ctrl_reg.wake_ffmt,
                   ctrl_reg.wake_vecm};

  // per function: always on in wake, on in sleep only if enabled
  for (genvar i = 0; i < 5; i++) begin : g_fn
    assign func_en_v[i] = ~sys_sleep | wake_v[i];
    assign live_v[i] = evt_v[i] & func_en_v[i];
  end
  assign func_enable = func_en_v;

  // wake request on a sleep event of an enabled function
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= sys_sleep & |(evt_v & wake_v);
    end
  end
  assign wake_req = wake_reg;

  // ----------------------------------------
  // interrupt pins
  // ----------------------------------------
  // or of sources per pin
  assign src_a = |(live_v & route_reg[4:0]);
  assign src_b = |(live_v & ~route_reg[4:0]);

  // pins registered so the pads see no glitches
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      // push-pull, active low, idle high
      pin_a_reg <= 2'b11;
      pin_b_reg <= 2'b11;
    end else if (ctrl_reg.irq_pin_drive_type) begin
      // low level means asserted when pol is 0
      pin_a_reg.o <= 1'b0;
      pin_b_reg.o <= 1'b0;
      pin_a_reg.oe <= src_a ^ ctrl_reg.irq_pin_pol;
      pin_b_reg.oe <= src_b ^ ctrl_reg.irq_pin_pol;
    end else begin
      pin_a_reg.o <= ~(src_a ^ ctrl_reg.irq_pin_pol);
      pin_b_reg.o <= ~(src_b ^ ctrl_reg.irq_pin_pol);
      pin_a_reg.oe <= 1'b1;
      pin_b_reg.oe <= 1'b1;
    end
  end
  assign event_pin_a = pin_a_reg;
  assign event_pin_b = pin_b_reg;

  // ----------------------------------------
  // block interrupt: sticky status, read clears
  // ----------------------------------------
  assign set_flush = flush_reg;
  assign set_wake = wake_reg;

  // set wins over the clear of a read in the same cycle
  always_comb begin
    stat_next = stat_reg;
    if (rd_acc && paddr == `SWIC_OFS_STAT) begin
      // clear only what the read reported; a bit set after the
      // setup cycle survives until the next read
      stat_next = stat_reg & ~rdata_reg[2:0];
    end
    if (set_gerr) begin
      stat_next[`SWIC_ST_GERR] = 1'b1;
    end
    if (set_flush) begin
      stat_next[`SWIC_ST_FLUSH] = 1'b1;
    end
    if (set_wake) begin
      stat_next[`SWIC_ST_WAKE] = 1'b1;
    end
  end

  // status register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stat_reg <= 3'h0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // level interrupt while an unmasked bit is set
  assign irq = |(stat_reg & mask_reg);
endmodule

//--- sim/swic_monitor.sv
// Purpose: port checker for swic_top
// Assumes: ctrl and route copies tracked from apb writes
// Notes: pin expectations follow the shadow copies
`timescale 1ns/1ps
`include "swic_defs.svh"
module swic_monitor import swic_pkg::*; #(
  parameter int RATE_W = 3
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic sys_sleep,
  input wire logic auto_sleep_en,
  input wire logic [RATE_W-1:0] output_sample_rate,
  input wire logic fifo_empty,
  input wire logic fifo_flush,
  input wire logic fifo_in_block,
  input wire swic_func_t func_event,
  input wire swic_func_t func_enable,
  input wire logic func_cnt_reset,
  input wire logic wake_req,
  input wire swic_pin_t event_pin_a,
  input wire swic_pin_t event_pin_b
);
  // -------------------------------------
  // helper state
  // -------------------------------------
  logic [7:0] ctrl; // shadow of the control register
  logic [4:0] route; // shadow of the routing bits, 1 to pin a
  logic [4:0] live; // events of functions allowed to run
  logic prev_slp; // mode seen last cycle
  logic [RATE_W-1:0] prev_rate; // rate seen last cycle
  swic_pin_t exp_a, exp_b; // expected pin flops
  // pin level from polarity and drive bits
  function automatic swic_pin_t pin(input logic [7:0] c, input logic s);
    return {!c[0] && (c[1] ? s : !s), c[0] ? s ^ c[1] : 1'b1};
  endfunction
  // functions run in wake, in sleep only with their wake bit
  assign live = func_event & ({5{!sys_sleep}} | ctrl[6:2]);
  // shadow copies, reset like the design
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= 8'h00;
      route <= 5'h00;
      prev_slp <= 1'b0;
      prev_rate <= '0;
      exp_a <= 2'h3;
      exp_b <= 2'h3;
    end else begin
      if (psel && penable && pwrite && paddr == `SWIC_OFS_CTRL) begin
        ctrl <= pwdata[7:0];
      end
      if (psel && penable && pwrite && paddr == `SWIC_OFS_ROUTE) begin
        route <= pwdata[4:0];
      end
      prev_slp <= sys_sleep;
      prev_rate <= output_sample_rate;
      exp_a <= pin(ctrl, |(live & route));
      exp_b <= pin(ctrl, |(live & ~route));
    end
  end
  // -------------------------------------
  // properties
  // -------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_chg;
    sys_sleep != prev_slp;
  endsequence
  sequence s_drain;
    fifo_in_block && fifo_empty && sys_sleep == prev_slp;
  endsequence
  chk_gate_off_flush:
    assert property (!ctrl[7] ##0 s_chg |=> fifo_flush) else $error("no flush");
  chk_gate_on_block:
    assert property (ctrl[7] ##0 s_chg |=> fifo_in_block) else $error("no block");
  chk_block_release:
    assert property (s_drain |=> !fifo_in_block) else $error("block held");
  chk_rate_flush:
    assert property (output_sample_rate != prev_rate |=> fifo_flush)
      else $error("rate flush missing");
  chk_sleep_enables:
    assert property (func_enable == ({5{!sys_sleep}} | ctrl[6:2]))
      else $error("enable mismatch");
  chk_wake_pulse:
    assert property (sys_sleep && |(func_event & ctrl[6:2]) |=> wake_req)
      else $error("no wake");
  chk_cnt_reset:
    assert property (auto_sleep_en ##0 s_chg |=> func_cnt_reset)
      else $error("no count reset");
  chk_pin_a_level:
    assert property (event_pin_a == exp_a) else $error("pin a wrong");
  chk_pin_b_or:
    assert property (event_pin_b == exp_b) else $error("pin b wrong");
endmodule
bind swic_top swic_monitor #(.RATE_W(RATE_W)) mon (.*);

//--- sim/swic_host_model.sv
// Purpose: host side fifo fill level model
// Assumes: host drains one sample a cycle on drain
// Notes: no read data, level only
`timescale 1ns/1ps
module swic_host_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sample_valid,
  input wire logic fifo_flush,
  input wire logic fifo_in_block,
  input wire logic drain,
  output logic fifo_empty,
  output logic [5:0] level
);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) level <= 6'h00;
    else if (fifo_flush) level <= 6'h00;
    else if (drain && level != 6'h00) level <= level - 6'h01;
    else if (sample_valid && !fifo_in_block) level <= level + 6'h01;
  end
  assign fifo_empty = (level == 6'h00);
endmodule

//--- sim/swic_top_tb.sv
// Purpose: self-checking bench for swic_top
// Assumes: apb master waits for pready, route set once for pin a
// Notes: one task per scenario
`timescale 1ns/1ps
`include "swic_defs.svh"
module swic_top_tb;
  import swic_pkg::*;
  logic ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, serr, irq, fifo_flush, fifo_in_block;
  logic sys_sleep = 0, auto_sleep_en = 0, sample_valid = 0, drain = 0;
  logic [2:0] output_sample_rate = 0;
  logic fifo_empty, func_cnt_reset, wake_req;
  logic [5:0] level;
  swic_func_t func_event = 0, func_enable;
  swic_pin_t event_pin_a, event_pin_b;
  int err_count = 0, checks = 0;
  swic_top dut (.*);
  swic_host_model host (.*);
  initial forever #20 ref_clk = !ref_clk;
  task automatic stop_test;
    $display("mismatches %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, string m);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // one apb transfer, launched right after the next rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      stop_test();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_regs;
    apb(0, `SWIC_OFS_CTRL, 0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1, `SWIC_OFS_CTRL, 32'hFF);
    apb(0, `SWIC_OFS_CTRL, 0);
    chk(rd, 32'hFF, "ctrl readback");
    apb(0, 8'h40, 0);
    chk(serr, 1, "unmapped");
    apb(1, `SWIC_OFS_CTRL, 0);
  endtask
  task automatic t_gate_off;
    sample_valid <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sample_valid <= 1'b0;
    sys_sleep <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk(level, 0, "mode flush");
    apb(0, `SWIC_OFS_STAT, 0);
    chk(rd[1], 1, "flush status");
    apb(0, `SWIC_OFS_MODE, 0);
    chk(rd[0], 1, "sleep mode");
  endtask
  task automatic t_gate_on;
    apb(1, `SWIC_OFS_CTRL, 32'h80);
    sample_valid <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sample_valid <= 1'b0;
    sys_sleep <= 1'b0;
    repeat (2) @(posedge ref_clk);
    sample_valid <= 1'b1;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    #1 chk(fifo_in_block, 1, "blocked");
    chk(level, 2, "kept, sample dropped");
    apb(0, `SWIC_OFS_MODE, 0);
    chk(rd[2:0], 3'h6, "gate error set");
    chk(irq, 0, "masked");
    apb(1, `SWIC_OFS_MASK, 1);
    #1 chk(irq, 1, "irq raised");
    repeat (10) @(posedge ref_clk);
    apb(0, `SWIC_OFS_MODE, 0);
    chk(rd[2:0], 3'h6, "gate error held");
    drain <= 1'b1;
    repeat (2) @(posedge ref_clk);
    drain <= 1'b0;
    repeat (2) @(posedge ref_clk);
    apb(0, `SWIC_OFS_MODE, 0);
    chk(rd[2:0], 3'h0, "error cleared");
    apb(0, `SWIC_OFS_STAT, 0);
    chk(rd[0], 1, "sticky status");
    #1 chk(irq, 0, "read clears");
    apb(1, `SWIC_OFS_MASK, 0);
  endtask
  task automatic t_wake;
    sys_sleep <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1, `SWIC_OFS_CTRL, 32'h04 << i);
      // every function but the enabled one fires first
      func_event <= 5'h1F ^ (5'h01 << i);
      @(posedge ref_clk);
      func_event <= 5'h01 << i;
      #1 chk(wake_req, 0, "disabled no wake");
      chk(func_enable, 5'h01 << i, "sleep enable");
      @(posedge ref_clk);
      func_event <= 5'h00;
      #1 chk(wake_req, 1, "wake pulse");
    end
  endtask
  task automatic t_pins;
    logic p, d;
    @(posedge ref_clk);
    sys_sleep <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      p = k[1];
      d = k[0];
      apb(1, `SWIC_OFS_CTRL, k);
      func_event <= 5'h11;
      @(posedge ref_clk);
      @(posedge ref_clk);
      func_event <= 5'h00;
      #1 chk(func_enable, 5'h1F, "wake enables");
      chk({event_pin_b, event_pin_a}, {!d && p, d ? !p : 1'b1,
        !d && !p, d ? p : 1'b1}, "pin levels");
    end
    // trans to pin a, the rest stays on pin b
    apb(1, `SWIC_OFS_ROUTE, 32'h10);
    apb(0, `SWIC_OFS_ROUTE, 0);
    chk(rd, 32'h10, "route readback");
    func_event <= 5'h10;
    @(posedge ref_clk);
    func_event <= 5'h00;
    #1 chk({event_pin_b, event_pin_a}, 4'h4, "pin a only");
  endtask
  task automatic t_rate;
    @(posedge ref_clk);
    sample_valid <= 1'b1;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    output_sample_rate <= 3'h5;
    repeat (3) @(posedge ref_clk);
    #1 chk(level, 0, "rate flush");
    @(posedge ref_clk);
    auto_sleep_en <= 1'b1;
    sys_sleep <= 1'b1;
    @(posedge ref_clk);
    #1 chk(func_cnt_reset, 1, "count reset");
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_gate_off();
    t_gate_on();
    t_wake();
    t_pins();
    t_rate();
    stop_test();
  end
endmodule
